// ===== hdl/adcsq_pkg.sv
// Shared constants and types for the converter sequencer and configuration block.
package adcsq_pkg;

  // ***************************************************************
  // Configuration word layout
  // ***************************************************************
  localparam int CFG_WIDTH = 14;
  localparam int UPDATE_BIT = 13;
  localparam int ARR_MSB = 12;
  localparam int ARR_LSB = 10;
  localparam int SINGLE_BIT = 11;
  localparam int LAST_MSB = 9;
  localparam int LAST_LSB = 7;
  localparam int BW_BIT = 6;
  localparam int REF_MSB = 5;
  localparam int REF_LSB = 3;
  localparam int SCAN_MSB = 2;
  localparam int SCAN_LSB = 1;
  localparam int READBACK_BIT = 0;
  localparam logic [13:0] CFG_RESET = 14'h3fff;
  localparam logic [3:0] BIT_COUNT_FULL = 4'he;
  localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;

  // ***************************************************************
  // Field encodings
  // ***************************************************************
  localparam logic [1:0] SCAN_OFF = 2'h0;
  localparam logic [1:0] SCAN_KEEP = 2'h1;
  localparam logic [1:0] SCAN_WITH_TEMP = 2'h2;
  localparam logic [1:0] SCAN_NO_TEMP = 2'h3;
  localparam logic [2:0] ARR_TEMP = 3'h3;
  localparam logic [2:0] ARR_GROUND = 3'h7;
  localparam logic [2:0] CHAN_ZERO = 3'h0;
  localparam logic [2:0] CHAN_ONE = 3'h1;
  localparam logic [2:0] CHAN_TWO = 3'h2;
  localparam logic [2:0] EVEN_MASK = 3'h6;
  localparam logic [2:0] REF_INT_LOW = 3'h0;
  localparam logic [2:0] REF_INT_HIGH = 3'h1;
  localparam logic [2:0] REF_EXTBUF_TEMP = 3'h2;
  localparam logic [2:0] REF_EXTBUF = 3'h3;
  localparam logic [2:0] REF_EXT_TEMP = 3'h6;
  localparam logic [2:0] REF_EXT = 3'h7;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int CONV_TIME_NS = 2200;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int CONV_COUNT_W = 10;
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);
  localparam logic [9:0] CONV_ZERO = 10'h000;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    ADCSQ_ACQUIRE = 2'b00,
    ADCSQ_CONVERT = 2'b01,
    ADCSQ_LATCH = 2'b11
  } adcsq_state_t;

  typedef enum logic [1:0] {
    ADCSQ_NEG_ODD = 2'b00,
    ADCSQ_NEG_COMMON = 2'b01,
    ADCSQ_NEG_GROUND = 2'b10
  } adcsq_neg_t;

endpackage

// ===== hdl/adcsq_top.sv
// Channel sequencer, serial configuration capture and reference control of the converter.
`timescale 1ns/1ps
module adcsq_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic convert_trigger,
  output logic conversion_busy,
  output logic converter_power_on,
  output logic [13:0] config_word,
  output logic [2:0] mux_positive_channel,
  output logic [2:0] mux_negative_channel,
  output adcsq_pkg::adcsq_neg_t mux_negative_kind,
  output logic temp_sensor_selected,
  output logic straight_binary_coding,
  output logic filter_bandwidth_bit,
  output logic ref_internal_enable,
  output logic ref_level_high,
  output logic ref_buffer_enable,
  output logic temp_sensor_enable,
  output logic sequencer_active
);

  // ***************************************************************
  // Serial clock domain: configuration shift register
  // ***************************************************************
  logic frame_open_q;
  logic frame_clear;
  logic [3:0] bit_count_q;
  logic skipped_q;
  logic [13:0] shift_q;
  logic word_full_q;

  // The serial side is held cleared outside a conversion, so a half-written word never
  // survives into the next frame and no serial edge is needed to end a frame.
  assign frame_clear = reset | ~frame_open_q;

  // First bit must be high or the whole frame is skipped; after fourteen bits the
  // word is frozen so that longer host transfers are harmless.
  always_ff @(posedge serial_clock or posedge frame_clear) begin
    if (frame_clear) begin
      bit_count_q <= adcsq_pkg::BIT_COUNT_ZERO;
      skipped_q <= 1'b0;
      shift_q <= 14'h0000;
      word_full_q <= 1'b0;
    end else if (!skipped_q && bit_count_q != adcsq_pkg::BIT_COUNT_FULL) begin
      if (bit_count_q == adcsq_pkg::BIT_COUNT_ZERO && !serial_data_in) begin
        skipped_q <= 1'b1;
      end else begin
        shift_q <= {shift_q[12:0], serial_data_in};
        bit_count_q <= bit_count_q + adcsq_pkg::BIT_COUNT_ONE;
        word_full_q <= (bit_count_q == adcsq_pkg::BIT_COUNT_FULL - adcsq_pkg::BIT_COUNT_ONE);
      end
    end
  end

  // ***************************************************************
  // Crossings into the main clock domain
  // ***************************************************************
  logic trig_meta_q;
  logic trig_sync_q;
  logic trig_prev_q;
  logic full_meta_q;
  logic full_sync_q;

  // Two-flop synchronisers; only the second stage is looked at by logic.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
      full_meta_q <= 1'b0;
      full_sync_q <= 1'b0;
    end else begin
      trig_meta_q <= convert_trigger;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
      full_meta_q <= word_full_q;
      full_sync_q <= full_meta_q;
    end
  end

  // ***************************************************************
  // Conversion timing
  // ***************************************************************
  adcsq_pkg::adcsq_state_t state_q;
  logic [9:0] conv_count_q;
  logic start_conv;

  assign start_conv = trig_sync_q & ~trig_prev_q;

  // A rising trigger in acquisition starts a conversion timed by the internal clock.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= adcsq_pkg::ADCSQ_ACQUIRE;
      conv_count_q <= adcsq_pkg::CONV_ZERO;
    end else begin
      unique case (state_q)
        adcsq_pkg::ADCSQ_ACQUIRE: begin
          conv_count_q <= adcsq_pkg::CONV_ZERO;
          if (start_conv) begin
            state_q <= adcsq_pkg::ADCSQ_CONVERT;
          end
        end
        adcsq_pkg::ADCSQ_CONVERT: begin
          conv_count_q <= conv_count_q + 10'h001;
          if (conv_count_q == adcsq_pkg::CONV_LAST) begin
            state_q <= adcsq_pkg::ADCSQ_LATCH;
          end
        end
        adcsq_pkg::ADCSQ_LATCH: begin
          state_q <= adcsq_pkg::ADCSQ_ACQUIRE;
        end
        default: begin
          state_q <= adcsq_pkg::ADCSQ_ACQUIRE;
        end
      endcase
    end
  end

  // The serial window is open from conversion start until the word has been latched.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_open_q <= 1'b0;
    end else if (state_q == adcsq_pkg::ADCSQ_ACQUIRE && start_conv) begin
      frame_open_q <= 1'b1;
    end else if (state_q == adcsq_pkg::ADCSQ_LATCH) begin
      frame_open_q <= 1'b0;
    end
  end

  // Analog core is powered only while converting, so power follows the sample rate.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      conversion_busy <= 1'b0;
      converter_power_on <= 1'b0;
    end else begin
      conversion_busy <= (state_q != adcsq_pkg::ADCSQ_ACQUIRE) | start_conv;
      converter_power_on <= (state_q != adcsq_pkg::ADCSQ_ACQUIRE) | start_conv;
    end
  end

  // ***************************************************************
  // Configuration and sequencer state
  // ***************************************************************
  logic [13:0] cfg_q;
  logic [13:0] cfg_d;
  logic seq_active_q;
  logic seq_active_d;
  logic seq_temp_incl_q;
  logic seq_temp_incl_d;
  logic seq_on_temp_q;
  logic seq_on_temp_d;
  logic [2:0] seq_index_q;
  logic [2:0] seq_index_d;
  logic take_word;
  logic cur_pair;
  logic [2:0] cur_last;
  logic [2:0] scan_top;
  logic [2:0] seq_step;
  logic [1:0] new_scan;
  logic restart_needed;

  // The word is stable in the serial register once its full flag has crossed over.
  assign take_word = full_sync_q & shift_q[adcsq_pkg::UPDATE_BIT];
  assign cur_pair = ~cfg_q[adcsq_pkg::SINGLE_BIT];
  assign cur_last = cfg_q[adcsq_pkg::LAST_MSB:adcsq_pkg::LAST_LSB];
  assign scan_top = cur_pair ? (cur_last & adcsq_pkg::EVEN_MASK) : cur_last;
  assign seq_step = cur_pair ? adcsq_pkg::CHAN_TWO : adcsq_pkg::CHAN_ONE;
  assign new_scan = shift_q[adcsq_pkg::SCAN_MSB:adcsq_pkg::SCAN_LSB];
  assign restart_needed =
    (shift_q[adcsq_pkg::SINGLE_BIT] != cfg_q[adcsq_pkg::SINGLE_BIT]) |
    (shift_q[adcsq_pkg::LAST_MSB:adcsq_pkg::LAST_LSB] != cur_last);

  // Next configuration and sequence position, evaluated for the end of a conversion.
  always_comb begin
    cfg_d = cfg_q;
    seq_active_d = seq_active_q;
    seq_temp_incl_d = seq_temp_incl_q;
    seq_on_temp_d = seq_on_temp_q;
    seq_index_d = seq_index_q;
    if (seq_active_q) begin
      if (seq_on_temp_q) begin
        seq_on_temp_d = 1'b0;
        seq_index_d = adcsq_pkg::CHAN_ZERO;
      end else if (seq_index_q >= scan_top) begin
        seq_on_temp_d = seq_temp_incl_q;
        seq_index_d = adcsq_pkg::CHAN_ZERO;
      end else begin
        seq_index_d = seq_index_q + seq_step;
      end
    end
    if (take_word) begin
      cfg_d = shift_q;
      unique case (new_scan)
        adcsq_pkg::SCAN_WITH_TEMP, adcsq_pkg::SCAN_NO_TEMP: begin
          seq_active_d = 1'b1;
          seq_temp_incl_d = (new_scan == adcsq_pkg::SCAN_WITH_TEMP);
          seq_on_temp_d = 1'b0;
          seq_index_d = adcsq_pkg::CHAN_ZERO;
        end
        adcsq_pkg::SCAN_KEEP: begin
          if (seq_active_q && restart_needed) begin
            seq_on_temp_d = 1'b0;
            seq_index_d = adcsq_pkg::CHAN_ZERO;
          end
        end
        adcsq_pkg::SCAN_OFF: begin
          seq_active_d = 1'b0;
          seq_on_temp_d = 1'b0;
          seq_index_d = adcsq_pkg::CHAN_ZERO;
        end
      endcase
    end
  end

  // Settings change only at the end of a conversion; a partial or skipped word leaves the
  // configuration as it was, and a scan-field value of 01 keeps the running scan going.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_q <= adcsq_pkg::CFG_RESET;
      seq_active_q <= 1'b1;
      seq_temp_incl_q <= 1'b0;
      seq_on_temp_q <= 1'b0;
      seq_index_q <= adcsq_pkg::CHAN_ZERO;
    end else if (state_q == adcsq_pkg::ADCSQ_LATCH) begin
      cfg_q <= cfg_d;
      seq_active_q <= seq_active_d;
      seq_temp_incl_q <= seq_temp_incl_d;
      seq_on_temp_q <= seq_on_temp_d;
      seq_index_q <= seq_index_d;
    end
  end

  // ***************************************************************
  // Input multiplexer selection
  // ***************************************************************
  logic [2:0] pos_d;
  logic [2:0] neg_d;
  adcsq_pkg::adcsq_neg_t kind_d;
  logic temp_d;
  logic [2:0] arrangement;

  assign arrangement = cfg_q[adcsq_pkg::ARR_MSB:adcsq_pkg::ARR_LSB];

  // In a paired scan the pair is even-positive, odd-negative whatever the low select bit.
  always_comb begin
    pos_d = seq_active_q ? seq_index_q : cur_last;
    neg_d = adcsq_pkg::CHAN_ZERO;
    kind_d = adcsq_pkg::ADCSQ_NEG_GROUND;
    temp_d = (arrangement == adcsq_pkg::ARR_TEMP) | (seq_active_q & seq_on_temp_q);
    if (cur_pair) begin
      kind_d = adcsq_pkg::ADCSQ_NEG_ODD;
      if (seq_active_q) begin
        pos_d = seq_index_q & adcsq_pkg::EVEN_MASK;
        neg_d = seq_index_q | adcsq_pkg::CHAN_ONE;
      end else begin
        neg_d = cur_last ^ adcsq_pkg::CHAN_ONE;
      end
    end else if (arrangement != adcsq_pkg::ARR_GROUND) begin
      kind_d = adcsq_pkg::ADCSQ_NEG_COMMON;
    end
  end

  // Selection is registered so the multiplexer sees clean levels for the next acquisition.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mux_positive_channel <= adcsq_pkg::CHAN_ZERO;
      mux_negative_channel <= adcsq_pkg::CHAN_ZERO;
      mux_negative_kind <= adcsq_pkg::ADCSQ_NEG_GROUND;
      temp_sensor_selected <= 1'b0;
      straight_binary_coding <= 1'b1;
      filter_bandwidth_bit <= 1'b1;
      sequencer_active <= 1'b0;
      config_word <= adcsq_pkg::CFG_RESET;
    end else begin
      mux_positive_channel <= pos_d;
      mux_negative_channel <= neg_d;
      mux_negative_kind <= kind_d;
      temp_sensor_selected <= temp_d;
      straight_binary_coding <= temp_d | cfg_q[adcsq_pkg::ARR_MSB];
      filter_bandwidth_bit <= cfg_q[adcsq_pkg::BW_BIT];
      sequencer_active <= seq_active_q;
      config_word <= cfg_q;
    end
  end

  // ***************************************************************
  // Reference, buffer and temperature sensor control
  // ***************************************************************
  logic [2:0] ref_sel;
  logic int_en_d;
  logic high_d;
  logic buf_en_d;
  logic tsens_d;

  assign ref_sel = cfg_q[adcsq_pkg::REF_MSB:adcsq_pkg::REF_LSB];

  // Six schemes; unused codes power everything down, the safest reading of a bad code.
  always_comb begin
    int_en_d = 1'b0;
    high_d = 1'b0;
    buf_en_d = 1'b0;
    tsens_d = 1'b0;
    unique case (ref_sel)
      adcsq_pkg::REF_INT_LOW, adcsq_pkg::REF_INT_HIGH: begin
        int_en_d = 1'b1;
        high_d = (ref_sel == adcsq_pkg::REF_INT_HIGH);
        buf_en_d = 1'b1;
        tsens_d = 1'b1;
      end
      adcsq_pkg::REF_EXTBUF_TEMP, adcsq_pkg::REF_EXTBUF: begin
        buf_en_d = 1'b1;
        tsens_d = (ref_sel == adcsq_pkg::REF_EXTBUF_TEMP);
      end
      adcsq_pkg::REF_EXT_TEMP: begin
        tsens_d = 1'b1;
      end
      default: begin
        tsens_d = 1'b0;
      end
    endcase
  end

  // Registered control levels toward the analog reference section.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ref_internal_enable <= 1'b0;
      ref_level_high <= 1'b0;
      ref_buffer_enable <= 1'b0;
      temp_sensor_enable <= 1'b0;
    end else begin
      ref_internal_enable <= int_en_d;
      ref_level_high <= high_d;
      ref_buffer_enable <= buf_en_d;
      temp_sensor_enable <= tsens_d;
    end
  end

endmodule

// ===== dv/adcsq_checker.sv
// Concurrent checks on the converter sequencer top-level ports.
`timescale 1ns/1ps
module adcsq_checker (
  input logic clock,
  input logic reset,
  input logic conversion_busy,
  input logic converter_power_on,
  input logic [13:0] config_word,
  input logic [2:0] mux_positive_channel,
  input logic [2:0] mux_negative_channel,
  input adcsq_pkg::adcsq_neg_t mux_negative_kind,
  input logic temp_sensor_selected,
  input logic straight_binary_coding,
  input logic ref_internal_enable,
  input logic temp_sensor_enable,
  input logic sequencer_active
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Counts busy cycles so that a conversion of the wrong length is caught at its end.
  logic [9:0] busy_len_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_len_q <= 10'h000;
    end else begin
      busy_len_q <= conversion_busy ? busy_len_q + 10'h001 : 10'h000;
    end
  end

  a_power_follows_busy: assert property (converter_power_on == conversion_busy)
    else $error("converter power differs from busy");
  a_conv_length: assert property ($fell(conversion_busy) |-> busy_len_q inside {[549:554]})
    else $error("conversion length wrong");
  a_cfg_at_end: assert property ($changed(config_word) |->
    !conversion_busy && $past(conversion_busy))
    else $error("config word changed outside conversion end");
  a_mux_at_end: assert property ($changed(mux_positive_channel) |->
    !conversion_busy && $past(conversion_busy))
    else $error("channel changed outside conversion end");
  a_pair_even_odd: assert property (sequencer_active && !temp_sensor_selected &&
    mux_negative_kind == adcsq_pkg::ADCSQ_NEG_ODD |->
    !mux_positive_channel[0] && mux_negative_channel == (mux_positive_channel | 3'h1))
    else $error("pair polarity wrong");
  a_temp_binary: assert property (temp_sensor_selected |-> straight_binary_coding)
    else $error("sensor result not straight binary");
  a_ref_temp_on: assert property (ref_internal_enable |-> temp_sensor_enable)
    else $error("internal reference without sensor");
  a_temp_code: assert property (temp_sensor_selected && sequencer_active &&
    config_word[12:10] != adcsq_pkg::ARR_TEMP |->
    config_word[2:1] != adcsq_pkg::SCAN_NO_TEMP)
    else $error("sensor slot without its scan code");

  c_pair_scan: cover property (sequencer_active && mux_negative_kind == adcsq_pkg::ADCSQ_NEG_ODD);
  c_temp_slot: cover property (temp_sensor_selected);
  c_fixed_channel: cover property ($fell(conversion_busy) && !sequencer_active);
endmodule

bind adcsq_top adcsq_checker chk_u (.clock(clock), .reset(reset),
  .conversion_busy(conversion_busy), .converter_power_on(converter_power_on),
  .config_word(config_word), .mux_positive_channel(mux_positive_channel),
  .mux_negative_channel(mux_negative_channel), .mux_negative_kind(mux_negative_kind),
  .temp_sensor_selected(temp_sensor_selected), .straight_binary_coding(straight_binary_coding),
  .ref_internal_enable(ref_internal_enable), .temp_sensor_enable(temp_sensor_enable),
  .sequencer_active(sequencer_active));

// ===== dv/adcsq_host_model.sv
// Host model that shifts configuration words into the converter over the serial link.
`timescale 1ns/1ps
module adcsq_host_model (
  output logic serial_clock,
  output logic serial_data_in
);
  // Link clock and data idle low, so no stray update can begin between frames.
  initial begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end

  // Sends n bits MSB first; a short count leaves a partial frame on purpose, and a
  // count above fourteen adds ones past bit 0 that the converter must ignore.
  task automatic send(input logic [13:0] word, input int n);
    #13;
    for (int i = 13; i > 13 - n; i--) begin
      serial_data_in = (i >= 0) ? word[i] : 1'b1;
      #32 serial_clock = 1'b1;
      #32 serial_clock = 1'b0;
    end
    serial_data_in = 1'b0;
  endtask
endmodule

// ===== dv/adcsq_tb_top.sv
// Self-checking testbench for the converter sequencer and configuration block.
`timescale 1ns/1ps
module adcsq_tb_top;
  logic clock, reset, serial_clock, serial_data_in, convert_trigger, conversion_busy;
  logic converter_power_on, temp_sensor_selected, straight_binary_coding, filter_bandwidth_bit;
  logic ref_internal_enable, ref_level_high, ref_buffer_enable, temp_sensor_enable;
  logic sequencer_active, temp_e, act_e, incl_e;
  logic [13:0] config_word, cfg_e;
  logic [2:0] mux_positive_channel, mux_negative_channel, idx_e;
  adcsq_pkg::adcsq_neg_t mux_negative_kind;
  logic [31:0] seed, r;
  int failures, total_checks;

  adcsq_top dut_u (.clock(clock), .reset(reset), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .convert_trigger(convert_trigger),
    .conversion_busy(conversion_busy), .converter_power_on(converter_power_on),
    .config_word(config_word), .mux_positive_channel(mux_positive_channel),
    .mux_negative_channel(mux_negative_channel), .mux_negative_kind(mux_negative_kind),
    .temp_sensor_selected(temp_sensor_selected), .straight_binary_coding(straight_binary_coding),
    .filter_bandwidth_bit(filter_bandwidth_bit), .ref_internal_enable(ref_internal_enable),
    .ref_level_high(ref_level_high), .ref_buffer_enable(ref_buffer_enable),
    .temp_sensor_enable(temp_sensor_enable), .sequencer_active(sequencer_active));
  adcsq_host_model host_u (.serial_clock(serial_clock), .serial_data_in(serial_data_in));

  // ********
  // Helpers
  // ********
  // Main clock, 4 ns period.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [13:0] mk(input logic [2:0] arr, input logic [2:0] last,
      input logic bw, input logic [2:0] refc, input logic [1:0] scan);
    return {1'b1, arr, last, bw, refc, scan, 1'b0};
  endfunction

  // Expected {internal, high level, buffer, sensor} for each reference code.
  function automatic logic [3:0] ref_exp(input logic [2:0] c);
    case (c)
      3'h0: return 4'hb;
      3'h1: return 4'hf;
      3'h2: return 4'h3;
      3'h3: return 4'h2;
      3'h6: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

  // Next sequencer position after one conversion end, given what was shifted in.
  function automatic void predict(input logic [13:0] w, input int n);
    logic [13:0] old;
    logic [2:0] top;
    logic upd;
    old = cfg_e;
    upd = (n >= 14) && w[13];
    if (upd) cfg_e = w;
    if (upd && w[2]) incl_e = !w[1];
    if (upd && w[2:1] != 2'h1) act_e = w[2];
    top = cfg_e[11] ? cfg_e[9:7] : (cfg_e[9:7] & 3'h6);
    if (!act_e) begin
      idx_e = cfg_e[9:7];
      temp_e = 1'b0;
    end else if (upd && (w[2:1] != 2'h1 || w[11] != old[11] || w[9:7] != old[9:7])) begin
      idx_e = 3'h0;
      temp_e = 1'b0;
    end else if (temp_e || idx_e >= top) begin
      temp_e = !temp_e && incl_e;
      idx_e = 3'h0;
    end else begin
      idx_e = idx_e + (cfg_e[11] ? 3'h1 : 3'h2);
    end
  endfunction

  task automatic check_outputs();
    adcsq_pkg::adcsq_neg_t nk;
    nk = (cfg_e[12:10] == 3'h7) ? adcsq_pkg::ADCSQ_NEG_GROUND : adcsq_pkg::ADCSQ_NEG_COMMON;
    if (!cfg_e[11]) nk = adcsq_pkg::ADCSQ_NEG_ODD;
    check("config", config_word, cfg_e);
    check("temp", 14'(temp_sensor_selected), 14'(temp_e | (cfg_e[12:10] == 3'h3)));
    check("binary", 14'(straight_binary_coding),
      14'(temp_e | (cfg_e[12:10] == 3'h3) | cfg_e[12]));
    check("bw", 14'(filter_bandwidth_bit), 14'(cfg_e[6]));
    check("ref", 14'({ref_internal_enable, ref_level_high, ref_buffer_enable,
      temp_sensor_enable}), 14'(ref_exp(cfg_e[5:3])));
    check("active", 14'(sequencer_active), 14'(act_e));
    if (!temp_e) begin
      check("pos", 14'(mux_positive_channel), 14'(idx_e));
      check("kind", 14'(mux_negative_kind), 14'(nk));
      if (!cfg_e[11]) check("neg", 14'(mux_negative_channel),
        14'(act_e ? (idx_e | 3'h1) : (idx_e ^ 3'h1)));
    end
  endtask

  // Inputs change 1 ns after the rising edge.
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic wait_busy(input logic level, input int limit);
    int k;
    k = 0;
    while (conversion_busy !== level && k < limit) begin
      tick();
      k++;
    end
    if (conversion_busy !== level) begin
      failures++;
      close_out();
    end
  endtask

  // One conversion; the word is shifted in while busy, well before the end.
  task automatic conv(input logic [13:0] w, input int n);
    tick();
    convert_trigger = 1'b1;
    wait_busy(1'b1, 10);
    convert_trigger = 1'b0;
    if (n > 0) host_u.send(w, n);
    wait_busy(1'b0, 700);
    tick();
    tick();
    predict(w, n);
    check_outputs();
  endtask

  // ********
  // Scenarios
  // ********
  initial begin
    reset = 1'b1;
    convert_trigger = 1'b0;
    seed = 32'h0001_7019;
    failures = 0;
    total_checks = 0;
    cfg_e = adcsq_pkg::CFG_RESET;
    act_e = 1'b1;
    incl_e = 1'b0;
    idx_e = 3'h0;
    temp_e = 1'b0;
    repeat (8) @(posedge clock);
    #1 reset = 1'b0;
    tick();
    check("reset word", config_word, 14'h3fff);
    repeat (9) conv(14'h0000, 0);
    $display("done: wrap");
    // Internal reference keeps the sensor powered for the sensor slot.
    conv(mk(3'h4, 3'h5, 1'b1, 3'h0, 2'h2), 14);
    repeat (5) conv(14'h0000, 0);
    conv(mk(3'h7, 3'h2, 1'b1, 3'h7, 2'h3), 10);
    conv(mk(3'h7, 3'h2, 1'b1, 3'h7, 2'h3) & 14'h1fff, 14);
    conv(mk(3'h7, 3'h7, 1'b1, 3'h7, 2'h3), 14);
    conv(14'h0000, 0);
    conv(mk(3'h7, 3'h7, 1'b0, 3'h7, 2'h1), 14);
    conv(mk(3'h7, 3'h4, 1'b0, 3'h7, 2'h1), 14);
    conv(mk(3'h4, 3'h4, 1'b0, 3'h7, 2'h1), 14);
    $display("done: updates");
    for (int i = 0; i < 8; i++) conv(mk(3'h7, 3'h7, 1'b1, 3'(i), 2'h3), 14);
    conv(mk(3'h6, 3'h3, 1'b1, 3'h7, 2'h0), 14);
    // A keep code while no scan runs must leave the scan off; the fixed channel moves from 3 to the new select 5.
    conv(mk(3'h7, 3'h5, 1'b1, 3'h7, 2'h1), 14);
    // Fixed pair with an odd select bit, then the sensor as the input arrangement.
    conv(mk(3'h4, 3'h3, 1'b1, 3'h7, 2'h0), 14);
    conv(mk(3'h3, 3'h2, 1'b1, 3'h0, 2'h0), 14);
    conv(14'h0000, 0);
    $display("done: references and fixed channel");
    repeat (24) begin
      r = rnd();
      conv(mk(r[2:0] == 3'h3 ? 3'h7 : r[2:0], r[5:3], r[6], r[10] ? r[9:7] : 3'h0,
        {1'b1, r[10]}), r[13:12] == 2'h0 ? 13 : (r[13:12] == 2'h1 ? 16 : 14));
    end
    $display("done: random");
    close_out();
  end
endmodule
